/* File: rtl/reset_source_condition_logic.sv */
`include "reset_source_defines.svh"

// Summary of operation
// - Illegal level code sets level fault flag.
// - Illegal level code resets the whole device.
// - Level fault flag clears only by software.
// - Running watchdog time-out gives full reset.
// - Sleeping time-out clears only counter, stack and watchdog.
// - Restart waits delay set by clock source.
// - Power-on clears time-out and power-down flags.
// - Low-voltage reset keeps time-out and power-down.
// - Running time-out sets time-out, keeps power-down.
// - Sleeping time-out sets both status flags.
// - Power-on disables every interrupt source.
// - Power-on clears watchdog, which then counts.
// - Power-on switches all timer counters off.
// - Power-on makes pins and channels inputs.
// - Power-on zeroes counter, stack points top.
// - Counter low byte zeroed by every reset.
// - Illegal unlock code resets after slow ticks.
// - Only four level codes; others restore default.
// - Unlock fault flag set, cleared by software.
// - Low-voltage flag set, cleared by software.
module reset_source_condition_logic
#(
	parameter int SLOW_DIV = `RSC_SLOW_DIV
)
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        lvr_detect,
	input  wire logic        wdt_timeout,
	input  wire logic        core_sleep,
	output logic             periph_reset,
	output logic             pc_sp_clear,
	output logic             wdt_clear,
	output logic             core_hold
);

	// ======================================================================
	// Elaboration check.
	// ======================================================================
	// A fault must wait over eight system clocks, so a tick needs at least four.
	generate
		if (SLOW_DIV < 4 || SLOW_DIV > 4096)
		begin : g_bad_div
			$error("SLOW_DIV out of range");
		end
	endgenerate

	// ======================================================================
	// Declarations.
	// ======================================================================
	reset_source_pkg::seq_state_t state_reg;     // Sequencer state.
	reset_source_pkg::seq_state_t state_next;    // Next sequencer state.
	reset_source_pkg::clk_src_t   clk_sel_reg;   // Restart clock source.
	logic [11:0] div_reg;                        // Slow tick divider.
	logic        tick_reg;                       // One-cycle slow tick.
	logic [7:0]  level_reg;                      // Level select register.
	logic [7:0]  level_next;                     // Its next value.
	logic [4:0]  unlock_reg;                     // Watchdog unlock field.
	logic [4:0]  unlock_next;                    // Its next value.
	logic        low_voltage_reset_flag_reg;     // Low-voltage reset flag.
	logic        level_select_fault_flag_reg;    // Level fault flag.
	logic        wdt_control_fault_flag_reg;     // Unlock fault flag.
	logic        watchdog_timeout_flag_reg;      // Time-out flag.
	logic        powerdown_flag_reg;             // Power-down flag.
	logic [7:0]  dly_cnt_reg;                    // Settle delay counter.
	logic [7:0]  dly_tgt_reg;                    // Settle delay length minus one.
	logic [1:0]  fault_cnt_reg [2];              // Slow ticks seen per fault.
	logic [1:0]  fault_bad;                      // Field holds illegal code.
	logic [1:0]  fault_done;                     // Fault waited long enough.
	logic        wait_reg;                       // Waitrequest flop.
	logic [31:0] rdata_reg;                      // Read data flop.
	logic        full_reset_reg;                 // Full reset pulse.
	logic        pcsp_reg;                       // Counter and stack clear pulse.
	logic        wdtclr_reg;                     // Watchdog clear pulse.
	logic        hold_reg;                       // Core held in restart.

	// ======================================================================
	// Bus decode.
	// ======================================================================
	// A request is served in the cycle after waitrequest drops.
	wire       bus_req   = avs_read | avs_write;
	wire       bus_take  = bus_req & ~wait_reg;
	wire [2:0] word_ofs  = avs_address[4:2];
	wire       wr_lane0  = avs_write & bus_take & avs_byteenable[0];
	wire       wr_ctrl   = wr_lane0 & (word_ofs == `RSC_OFS_CTRL);
	wire       wr_level  = wr_lane0 & (word_ofs == `RSC_OFS_LEVEL);
	wire       wr_unlock = wr_lane0 & (word_ofs == `RSC_OFS_UNLOCK);
	wire       wr_clksel = wr_lane0 & (word_ofs == `RSC_OFS_CLKSEL);
	// Writing a zero to a flag bit clears it; a one leaves it alone.
	wire       clr_wdtf  = wr_ctrl & ~avs_writedata[`RSC_CTRL_WDT_FAULT_BIT];
	wire       clr_lvlf  = wr_ctrl & ~avs_writedata[`RSC_CTRL_LVL_FAULT_BIT];
	wire       clr_lowv  = wr_ctrl & ~avs_writedata[`RSC_CTRL_LOW_VOLT_BIT];

	// Read multiplexer; unmapped words read as zero.
	wire [31:0] rd_mux =
		(word_ofs == `RSC_OFS_CTRL)   ? {29'h0, low_voltage_reset_flag_reg,
			level_select_fault_flag_reg, wdt_control_fault_flag_reg} :
		(word_ofs == `RSC_OFS_LEVEL)  ? {24'h0, level_reg} :
		(word_ofs == `RSC_OFS_UNLOCK) ? {27'h0, unlock_reg} :
		(word_ofs == `RSC_OFS_STATUS) ? {30'h0, powerdown_flag_reg, watchdog_timeout_flag_reg} :
		(word_ofs == `RSC_OFS_CLKSEL) ? {30'h0, clk_sel_reg} : 32'h0;

	// ======================================================================
	// Fault detection and event arbitration.
	// ======================================================================
	// Only the four defined level codes are legal.
	assign fault_bad[0] = ~((level_reg == `RSC_LEVEL_POR) | (level_reg == `RSC_LEVEL_OK1) |
		(level_reg == `RSC_LEVEL_OK2) | (level_reg == `RSC_LEVEL_OK3));
	// Only the enable and disable codes are legal in the unlock field.
	assign fault_bad[1] = ~((unlock_reg == `RSC_UNLOCK_POR) | (unlock_reg == `RSC_UNLOCK_OFF));

	wire running  = (state_reg == reset_source_pkg::ST_RUN);
	// The low-voltage detector is off while the core is powered down.
	wire lvr_go   = running & lvr_detect & ~core_sleep;
	wire lvl_go   = running & fault_done[0] & ~lvr_go;
	wire unl_go   = running & fault_done[1] & ~lvr_go;
	// The watchdog yields to any more severe cause in the same cycle.
	wire wdt_go   = running & wdt_timeout & ~(lvr_go | lvl_go | unl_go);
	wire wdt_full = wdt_go & ~core_sleep;
	wire wake_go  = wdt_go & core_sleep;
	wire full_go  = lvr_go | lvl_go | unl_go | wdt_full;
	wire any_go   = full_go | wake_go;

	// Settle step: slow clock counts slow ticks, others count system clocks.
	wire dly_step = (clk_sel_reg == reset_source_pkg::CLK_SLOW_RC) ? tick_reg : 1'b1;
	wire dly_end  = dly_step & (dly_cnt_reg == dly_tgt_reg);
	// Settle length for the selected oscillator, minus one.
	wire [7:0] dly_len =
		(clk_sel_reg == reset_source_pkg::CLK_XTAL)    ? `RSC_SETTLE_XTAL_M1 :
		(clk_sel_reg == reset_source_pkg::CLK_SLOW_RC) ? `RSC_SETTLE_SLOW_M1 : `RSC_SETTLE_FAST_M1;

	// Level: restored on its fault or a running time-out; a restore beats a write.
	assign level_next = (lvl_go | wdt_full) ? `RSC_LEVEL_POR :
		wr_level ? avs_writedata[7:0] : level_reg;
	// Unlock field returns to its default on every full reset.
	assign unlock_next = full_go ? `RSC_UNLOCK_POR :
		wr_unlock ? avs_writedata[4:0] : unlock_reg;

	// ======================================================================
	// Sequencer next state.
	// ======================================================================
	// Any accepted event restarts the settle delay.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			reset_source_pkg::ST_RUN:
			begin
				if (any_go)
				begin
					state_next = reset_source_pkg::ST_SETTLE;
				end
			end
			reset_source_pkg::ST_SETTLE:
			begin
				if (dly_end)
				begin
					state_next = reset_source_pkg::ST_RUN;
				end
			end
		endcase
	end

	// ======================================================================
	// Slow tick divider.
	// ======================================================================
	// Stands in for the slow internal RC as a one-cycle enable.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			div_reg  <= 12'h000;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= (div_reg == 12'(SLOW_DIV - 1));
			div_reg  <= (div_reg == 12'(SLOW_DIV - 1)) ? 12'h000 : div_reg + 12'h001;
		end
	end

	// ======================================================================
	// Fault wait counters.
	// ======================================================================
	// Three slow ticks while illegal give 2 to 3 slow periods of delay.
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_fault
			assign fault_done[i] = (fault_cnt_reg[i] == `RSC_FAULT_TICKS);
			always_ff @(posedge sys_clk)
			begin
				if (!rstn || !fault_bad[i] || full_go)
				begin
					fault_cnt_reg[i] <= 2'h0;
				end
				else if (tick_reg && !fault_done[i])
				begin
					fault_cnt_reg[i] <= fault_cnt_reg[i] + 2'h1;
				end
			end
		end
	endgenerate

	// ======================================================================
	// Sticky flags and status.
	// ======================================================================
	// Hardware sets win over software clears in the same cycle.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			low_voltage_reset_flag_reg  <= 1'b0;
			level_select_fault_flag_reg <= 1'b0;
			wdt_control_fault_flag_reg  <= 1'b0;
			watchdog_timeout_flag_reg   <= 1'b0;
			powerdown_flag_reg          <= 1'b0;
		end
		else
		begin
			low_voltage_reset_flag_reg  <= lvr_go | (low_voltage_reset_flag_reg & ~clr_lowv);
			level_select_fault_flag_reg <= fault_bad[0] | (level_select_fault_flag_reg & ~clr_lvlf);
			wdt_control_fault_flag_reg  <= unl_go | (wdt_control_fault_flag_reg & ~clr_wdtf);
			watchdog_timeout_flag_reg   <= wdt_go | watchdog_timeout_flag_reg;
			powerdown_flag_reg          <= wake_go | powerdown_flag_reg;
		end
	end

	// ======================================================================
	// Software-visible configuration.
	// ======================================================================
	// Level, unlock and clock select registers.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			level_reg   <= `RSC_LEVEL_POR;
			unlock_reg  <= `RSC_UNLOCK_POR;
			clk_sel_reg <= reset_source_pkg::CLK_FAST_RC;
		end
		else
		begin
			level_reg  <= level_next;
			unlock_reg <= unlock_next;
			if (wr_clksel)
			begin
				clk_sel_reg <= reset_source_pkg::clk_src_t'(avs_writedata[1:0]);
			end
		end
	end

	// ======================================================================
	// Sequencer and reset outputs.
	// ======================================================================
	// Power-on holds everything in reset; other events give one-cycle pulses.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			state_reg      <= reset_source_pkg::ST_SETTLE;
			dly_cnt_reg    <= 8'h00;
			dly_tgt_reg    <= `RSC_SETTLE_FAST_M1;
			full_reset_reg <= 1'b1;
			pcsp_reg       <= 1'b1;
			wdtclr_reg     <= 1'b1;
			hold_reg       <= 1'b1;
		end
		else
		begin
			state_reg      <= state_next;
			full_reset_reg <= full_go;
			pcsp_reg       <= any_go;
			wdtclr_reg     <= any_go;
			hold_reg       <= (state_next != reset_source_pkg::ST_RUN);
			if (any_go)
			begin
				dly_cnt_reg <= 8'h00;
				dly_tgt_reg <= dly_len;
			end
			else if (!running && dly_step)
			begin
				dly_cnt_reg <= dly_cnt_reg + 8'h01;
			end
		end
	end

	// ======================================================================
	// Bus response.
	// ======================================================================
	// Waitrequest drops for one cycle per request, read data stand with it.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end
		else
		begin
			wait_reg <= ~(bus_req & wait_reg);
			if (avs_read && wait_reg)
			begin
				rdata_reg <= rd_mux;
			end
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;
	assign periph_reset    = full_reset_reg;
	assign pc_sp_clear     = pcsp_reg;
	assign wdt_clear       = wdtclr_reg;
	assign core_hold       = hold_reg;

	// ======================================================================
	// Assertions.
	// ======================================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	AST_LVL_FLAG_SET: assert property (fault_bad[0] |=> level_select_fault_flag_reg)
		else $error("level fault flag not set");
	AST_LVL_RESET: assert property (lvl_go |=> periph_reset && level_reg == `RSC_LEVEL_POR)
		else $error("level fault did not reset");
	AST_LVL_STICKY: assert property (level_select_fault_flag_reg && !clr_lvlf |=> level_select_fault_flag_reg)
		else $error("level fault flag dropped");
	AST_WDT_FULL: assert property (wdt_full |=> periph_reset && watchdog_timeout_flag_reg
		&& $stable(powerdown_flag_reg))
		else $error("running time-out wrong");
	AST_WDT_WAKE: assert property (wake_go |=> pc_sp_clear && !periph_reset
		&& watchdog_timeout_flag_reg && powerdown_flag_reg)
		else $error("sleeping time-out wrong");
	AST_SETTLE_FAST: assert property (any_go && clk_sel_reg == reset_source_pkg::CLK_FAST_RC && !wr_clksel
		|=> core_hold ##15 core_hold ##1 !core_hold)
		else $error("fast settle length wrong");
	AST_SETTLE_XTAL: assert property (any_go && clk_sel_reg == reset_source_pkg::CLK_XTAL && !wr_clksel
		|=> core_hold ##127 core_hold ##1 !core_hold)
		else $error("crystal settle length wrong");
	AST_POR_FLAGS: assert property (@(posedge sys_clk) disable iff (1'b0)
		!rstn |=> !watchdog_timeout_flag_reg && !powerdown_flag_reg && periph_reset && pc_sp_clear)
		else $error("power-on state wrong");
	AST_LVR_KEEP: assert property (lvr_go |=> $stable(watchdog_timeout_flag_reg) && $stable(powerdown_flag_reg)
		&& low_voltage_reset_flag_reg && periph_reset)
		else $error("low-voltage reset changed flags");
	AST_UNL_FAULT: assert property (unl_go |=> wdt_control_fault_flag_reg && unlock_reg == `RSC_UNLOCK_POR)
		else $error("unlock fault handling wrong");
	AST_UNL_WAIT: assert property ($rose(fault_bad[1]) && running |-> !unl_go [*8])
		else $error("unlock fault reset too early");
	AST_PRIO: assert property (lvr_go && wdt_timeout |=> $stable(watchdog_timeout_flag_reg))
		else $error("watchdog beat low-voltage reset");
	AST_PCSP: assert property (periph_reset |-> pc_sp_clear && wdt_clear)
		else $error("full reset without counter clear");

	COV_WAKE: cover property (wake_go ##1 core_hold [*3]);
	COV_LVR: cover property (lvr_go ##1 periph_reset);
	COV_LVL: cover property (lvl_go ##1 (periph_reset && level_reg == `RSC_LEVEL_POR));
	COV_CLR_SET: cover property (clr_lowv && lvr_go);

endmodule

/* File: rtl/reset_source_defines.svh */
`ifndef RESET_SOURCE_DEFINES_SVH
`define RESET_SOURCE_DEFINES_SVH

// ==========================================================================
// Register word offsets on the Avalon-MM slave.
// ==========================================================================
`define RSC_OFS_CTRL        3'h0
`define RSC_OFS_LEVEL       3'h1
`define RSC_OFS_UNLOCK      3'h2
`define RSC_OFS_STATUS      3'h3
`define RSC_OFS_CLKSEL      3'h4

// ==========================================================================
// Field positions.
// ==========================================================================
`define RSC_CTRL_WDT_FAULT_BIT  0
`define RSC_CTRL_LVL_FAULT_BIT  1
`define RSC_CTRL_LOW_VOLT_BIT   2
`define RSC_STAT_TIMEOUT_BIT    0
`define RSC_STAT_PWRDN_BIT      1

// ==========================================================================
// Reset values and legal codes.
// ==========================================================================
`define RSC_LEVEL_POR       8'h55
`define RSC_LEVEL_OK1       8'h33
`define RSC_LEVEL_OK2       8'h99
`define RSC_LEVEL_OK3       8'haa
`define RSC_UNLOCK_POR      5'h0a
`define RSC_UNLOCK_OFF      5'h15

// ==========================================================================
// Timing.
// ==========================================================================
`define RSC_SYS_FREQ_HZ     20000000
`define RSC_SLOW_FREQ_HZ    32000
`define RSC_SLOW_DIV        (`RSC_SYS_FREQ_HZ / `RSC_SLOW_FREQ_HZ)
`define RSC_FAULT_TICKS     2'h3
`define RSC_SETTLE_FAST_M1  8'h0f
`define RSC_SETTLE_XTAL_M1  8'h7f
`define RSC_SETTLE_SLOW_M1  8'h01

`endif

/* File: rtl/reset_source_pkg.sv */
// ==========================================================================
// Types shared by the reset-source logic.
// ==========================================================================
package reset_source_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [1:0]
	{
		ST_SETTLE = 2'b01,
		ST_RUN    = 2'b10
	} seq_state_t;

	// Oscillator that clocks the core after a restart.
	typedef enum logic [1:0]
	{
		CLK_FAST_RC = 2'h0,
		CLK_XTAL    = 2'h1,
		CLK_SLOW_RC = 2'h2,
		CLK_SPARE   = 2'h3
	} clk_src_t;

endpackage

/* File: verif/far_side_model.sv */
// ==========================================================================
// Watchdog, low-voltage detector and core sleep state as seen by the block.
// ==========================================================================
module far_side_model
(
	input  wire logic sys_clk,
	output logic      lvr_detect,
	output logic      wdt_timeout,
	output logic      core_sleep
);
	timeunit 1ns;
	timeprecision 1ns;

	// Everything idles low: running core, no alarm.
	initial
	begin
		lvr_detect = 1'b0;
		wdt_timeout = 1'b0;
		core_sleep = 1'b0;
	end

	// One-cycle alarm pulse, launched just after an edge so the block samples it once.
	task automatic fire(input logic lv, input logic wd);
		lvr_detect <= lv;
		wdt_timeout <= wd;
		@(posedge sys_clk);
		lvr_detect <= 1'b0;
		wdt_timeout <= 1'b0;
	endtask

	// The core enters or leaves the power-down state.
	task automatic set_sleep(input logic s);
		core_sleep <= s;
	endtask
endmodule

/* File: verif/tb.sv */
`include "reset_source_defines.svh"

// ==========================================================================
// Self-checking bench for the reset-source logic.
// ==========================================================================
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DIV = 8; // Short slow-clock divider keeps fault waits brief.
	logic        sys_clk, rstn, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        lvr_detect, wdt_timeout, core_sleep;
	logic        periph_reset, pc_sp_clear, wdt_clear, core_hold;
	int          err_total, compares, cyc, seed, n, t0, k;
	logic [31:0] rd, v;

	reset_source_condition_logic #(.SLOW_DIV(DIV)) reset_source_condition_logic_inst
	(
		.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lvr_detect(lvr_detect),
		.wdt_timeout(wdt_timeout), .core_sleep(core_sleep), .periph_reset(periph_reset),
		.pc_sp_clear(pc_sp_clear), .wdt_clear(wdt_clear), .core_hold(core_hold)
	);
	far_side_model far_side_model_inst
	(
		.sys_clk(sys_clk), .lvr_detect(lvr_detect), .wdt_timeout(wdt_timeout), .core_sleep(core_sleep)
	);

	// Clock of 50 ns and a free cycle counter for latency checks.
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	// ==========================================================================
	// Checking and closing.
	// ==========================================================================
	task automatic end_sim();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Compares a design value bit for bit, so an unknown never matches.
	task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Checks a measured cycle count against an allowed window.
	task automatic chk_range(input string nm, input int lo, input int hi, input int got);
		compares++;
		if (got < lo || got > hi)
		begin
			err_total++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	// Settle window per clock source: fast RC, crystal, slow RC, spare acts as fast.
	function automatic int settle_lo(input int src);
		return (src == 1) ? 128 : (src == 2) ? DIV : 15;
	endfunction
	function automatic int settle_hi(input int src);
		return (src == 1) ? 128 : (src == 2) ? 2 * DIV + 1 : 16;
	endfunction

	// ==========================================================================
	// Drivers.
	// ==========================================================================
	// One Avalon transfer; the request stands until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [2:0] ofs, input logic [31:0] wd, output logic [31:0] q);
		int w;
		w = 0;
		@(posedge sys_clk);
		avs_address <= {ofs, 2'b00};
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && w < 20)
		begin
			@(posedge sys_clk);
			w++;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk_range("bus_wait", 0, 19, w);
	endtask
	task automatic rd_chk(input string nm, input logic [2:0] ofs, input logic [31:0] exp);
		bus(1'b0, ofs, 32'h0, rd);
		chk_val(nm, exp, rd);
	endtask
	// Waits for the clear pulse; n counts the edges it took.
	task automatic wait_pulse(input int maxc);
		n = 0;
		while (pc_sp_clear !== 1'b1 && n < maxc)
		begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	// Counts cycles of the restart hold; n is its length.
	task automatic hold_len();
		n = 0;
		while (core_hold === 1'b1 && n < 400)
		begin
			n++;
			@(posedge sys_clk);
		end
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_val("reset_outs", 4'hf, {periph_reset, pc_sp_clear, wdt_clear, core_hold});
		rstn <= 1'b1;
		@(posedge sys_clk);
		hold_len();
		chk_range("por_settle", settle_lo(0), settle_hi(0), n);
	endtask
	// A running or sleeping alarm, checked for pulse kind and then waited out.
	task automatic alarm(input logic lv, input logic wd, input logic [31:0] full);
		far_side_model_inst.fire(lv, wd);
		wait_pulse(4);
		chk_range("event_delay", 1, 2, n);
		chk_val("full_reset", full, periph_reset);
		chk_val("wdt_clear", 32'h1, wdt_clear);
		hold_len();
	endtask

	// ==========================================================================
	// Scenarios.
	// ==========================================================================
	initial
	begin
		rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
		avs_writedata = 32'h0; avs_byteenable = 4'hf; err_total = 0; compares = 0; cyc = 0; seed = 89;
		do_reset();
		rd_chk("ctrl_por", `RSC_OFS_CTRL, 32'h0);
		rd_chk("level_por", `RSC_OFS_LEVEL, 32'h55);
		rd_chk("unlock_por", `RSC_OFS_UNLOCK, 32'h0a);
		rd_chk("status_por", `RSC_OFS_STATUS, 32'h0);
		rd_chk("unmapped", 3'h5, 32'h0);
		// Low voltage and watchdog together: the low-voltage reset wins.
		alarm(1'b1, 1'b1, 32'h1);
		rd_chk("both_ctrl", `RSC_OFS_CTRL, 32'h4);
		rd_chk("both_status", `RSC_OFS_STATUS, 32'h0);
		bus(1'b1, `RSC_OFS_CTRL, 32'h0, rd);
		rd_chk("lvf_clear", `RSC_OFS_CTRL, 32'h0);
		// Running time-out restores the level code.
		bus(1'b1, `RSC_OFS_LEVEL, 32'h33, rd);
		alarm(1'b0, 1'b1, 32'h1);
		rd_chk("wdt_status", `RSC_OFS_STATUS, 32'h1);
		rd_chk("wdt_level", `RSC_OFS_LEVEL, 32'h55);
		// Low-voltage reset keeps status and level.
		bus(1'b1, `RSC_OFS_LEVEL, 32'h99, rd);
		alarm(1'b1, 1'b0, 32'h1);
		rd_chk("lvr_status", `RSC_OFS_STATUS, 32'h1);
		rd_chk("lvr_level", `RSC_OFS_LEVEL, 32'h99);
		rd_chk("lvr_ctrl", `RSC_OFS_CTRL, 32'h4);
		// Sleeping time-out clears only counter, stack and watchdog.
		far_side_model_inst.set_sleep(1'b1);
		// The low-voltage detector is off while powered down: no reset follows.
		far_side_model_inst.fire(1'b1, 1'b0);
		wait_pulse(4);
		chk_range("sleep_lvr_ignored", 4, 4, n);
		alarm(1'b0, 1'b1, 32'h0);
		rd_chk("slp_status", `RSC_OFS_STATUS, 32'h3);
		rd_chk("slp_level", `RSC_OFS_LEVEL, 32'h99);
		rd_chk("slp_ctrl", `RSC_OFS_CTRL, 32'h4);
		far_side_model_inst.set_sleep(1'b0);
		// Restart hold for every clock source code.
		for (k = 0; k < 4; k++)
		begin
			bus(1'b1, `RSC_OFS_CLKSEL, k, rd);
			rd_chk("clksel", `RSC_OFS_CLKSEL, k);
			far_side_model_inst.fire(1'b0, 1'b1);
			wait_pulse(4);
			hold_len();
			chk_range("settle", settle_lo(k), settle_hi(k), n);
		end
		bus(1'b1, `RSC_OFS_CLKSEL, 32'h0, rd);
		bus(1'b1, `RSC_OFS_CTRL, 32'h0, rd);
		// All four legal level codes are accepted without a fault.
		for (k = 0; k < 4; k++)
		begin
			bus(1'b1, `RSC_OFS_LEVEL, (k == 0) ? 32'h55 : (k == 1) ? 32'h33 : (k == 2) ? 32'h99 : 32'haa, rd);
			rd_chk("legal_ctrl", `RSC_OFS_CTRL, 32'h0);
		end
		// Random illegal level and unlock codes force a delayed full reset.
		for (k = 0; k < 6; k++)
		begin
			v = $random(seed);
			if (k < 3)
			begin
				while (v[7:0] == 8'h55 || v[7:0] == 8'h33 || v[7:0] == 8'h99 || v[7:0] == 8'haa) v = $random(seed);
				v = {24'h0, v[7:0]};
			end
			else
			begin
				while (v[4:0] == 5'h0a || v[4:0] == 5'h15) v = $random(seed);
				v = {27'h0, v[4:0]};
			end
			bus(1'b1, (k < 3) ? `RSC_OFS_LEVEL : `RSC_OFS_UNLOCK, v, rd);
			t0 = cyc;
			// The level flag follows the code at once; the unlock flag waits for the reset.
			rd_chk("fault_flag", `RSC_OFS_CTRL, (k < 3) ? 32'h2 : 32'h0);
			wait_pulse(60);
			chk_val("fault_full", 32'h1, periph_reset);
			chk_range("fault_delay", 2 * DIV, 3 * DIV + 3, cyc - t0);
			hold_len();
			rd_chk("fault_level", `RSC_OFS_LEVEL, 32'h55);
			rd_chk("fault_unlock", `RSC_OFS_UNLOCK, 32'h0a);
			rd_chk("fault_sticky", `RSC_OFS_CTRL, (k < 3) ? 32'h2 : 32'h1);
			bus(1'b1, `RSC_OFS_CTRL, 32'h0, rd);
			rd_chk("fault_clear", `RSC_OFS_CTRL, 32'h0);
		end
		// Power-on in mid-run clears the status flags again.
		do_reset();
		rd_chk("por_status", `RSC_OFS_STATUS, 32'h0);
		end_sim();
	end

	// Cuts a hang short well past the expected run length.
	initial
	begin
		#2000000;
		err_total++;
		end_sim();
	end
endmodule
